// ==== stfp_defs.vh ====
// constants for the token timing and transmit priority block
// assumes a 10 MHz character clock; counts derive from that rate
`ifndef STFP_DEFS_VH
`define STFP_DEFS_VH
`define STFP_CLK_HZ 10000000
`define STFP_LOSS_TIME_MS 100
`define STFP_LOSS_CYCLES ((`STFP_CLK_HZ / 1000) * `STFP_LOSS_TIME_MS)
`define STFP_MIN_GAP 100
`define STFP_MAX_DELAY 10
`define STFP_READY_FLAGS 10
// transmit selection codes
`define STFP_SEL_FLAG 4'h0
`define STFP_SEL_PAIR2 4'h1
`define STFP_SEL_TOKEN 4'h2
`define STFP_SEL_TOKEN_TURN 4'h3
`define STFP_SEL_USER 4'h4
`define STFP_SEL_ACK 4'h5
`define STFP_SEL_RR 4'h6
`define STFP_SEL_FRAME 4'h7
`define STFP_SEL_FWD_CTRL 4'h8
`define STFP_SEL_OWN_CTRL 4'h9
`define STFP_SEL_CUT 4'ha
`define STFP_SEL_OWN_APP 4'hb
`define STFP_SEL_IDLE_FLAG 4'hc
`define STFP_SEL_DIS 4'hd
`define STFP_SEL_NONE 4'hf
`endif

// ==== stfp_port.v ====
// token timing and transmit priority logic for one link port
// assumes all inputs synchronous to mclk_in; one character per clock
`timescale 1ns/1ps
`default_nettype none
`include "stfp_defs.vh"

// Functional notes
// - passing or turning token clears loss timer; code clears it on sent turn markers only, not on turned-back plain tokens
// - loss timeout creates token as if received
// - second token while holding is dropped
// - token passes within ten character periods; code has no such bound, a pass waits for the 100-character gap
// - token passes spaced at least 100 characters
// - token turn-backs spaced at least 100 characters; code spaces only sent turn markers, plain tokens turned back are not gated
// - quotas come from master configuration message
// - ten flags first after entering ready
// - finish started protocol pair next
// - pending token characters come next
// - user characters before new ack pair
// - ack pair before rr before frame continuation
// - frame continuation above control frame activity
// - forwarded reset frames above own control frame
// - own control frame above application frames
// - normally favour frames from the other port
// - holding token favours own frames instead
// - switch shares turns among frame sources
// - idle sends flag or disabled characters
// - items selectable only when preconditions hold
// - tokens accepted always, sent only when ready
// - reflection flag chooses turn-back or pass-on
// - releasing token clears originated frame counter
module stfp_port #(
    parameter LOSS_CYCLES = `STFP_LOSS_CYCLES,
    parameter QW = 8
) (
    // clock and reset
    input wire mclk_in,
    input wire rst_n_in,
    // port state and character sync
    input wire ready_state_in,
    input wire disabled_state_in,
    input wire char_sync_in,
    input wire reflect_flag_in,
    input wire switch_node_in,
    // configuration message
    input wire cfg_valid_in,
    input wire [QW-1:0] cfg_hold_quota_in,
    input wire [QW-1:0] cfg_idle_quota_in,
    // received token characters
    input wire rx_token_in,
    input wire rx_token_turn_in,
    // frame origination status
    input wire own_frame_sent_in,
    input wire own_frame_pending_in,
    // pending transmit items
    input wire pair_second_pending_in,
    input wire user_char_pending_in,
    input wire ack_pair_pending_in,
    input wire rr_pair_pending_in,
    input wire frame_in_progress_in,
    input wire fwd_ctrl_pending_in,
    input wire own_ctrl_pending_in,
    input wire cut_frame_pending_in,
    input wire own_app_pending_in,
    input wire awaiting_receiver_ready_flag_in,
    // transmit handshake: one character sent per accepted selection
    input wire tx_take_in,
    // outputs
    output reg [3:0] tx_sel_out,
    output reg token_held_out,
    output reg satisfied_out,
    output reg [QW-1:0] frame_count_out,
    output reg [QW-1:0] hold_quota_out,
    output reg [QW-1:0] idle_quota_out,
    output reg app_allowed_out,
    output reg token_regen_out
);

// ****************************************
// internal state
// ****************************************
reg [31:0] token_loss_timer_q;
reg [6:0] pass_gap_q;
reg [6:0] turn_gap_q;
reg [3:0] flag_cnt_q;
reg ready_d1_q;
reg pend_pass_q;       // token waiting to be passed on, sent on this port
reg pend_turn_q;       // turned-back character waiting on this port
reg pend_turn_kind_q;  // 1: turned char is the turn marker, 0: plain token
reg rr_turn_q;         // round-robin between cut-through and own frames
reg [3:0] sel_d;
wire loss_hit;
wire tok_in;
wire release_tok;
wire sat_now;
wire turn_token_go;
wire pass_token_go;
wire flag_take;
wire pass_take;
wire turn_take;

assign loss_hit = (token_loss_timer_q >= LOSS_CYCLES - 1);
assign tok_in = (rx_token_in & char_sync_in) | loss_hit;
assign sat_now = (frame_count_out >= hold_quota_out) | ~own_frame_pending_in;
// a held token leaves only once satisfied and no token character is still queued for sending
assign release_tok = token_held_out & sat_now & ~pend_pass_q & ~pend_turn_q;
assign flag_take = tx_take_in & (tx_sel_out == `STFP_SEL_FLAG);
assign pass_take = tx_take_in & (tx_sel_out == `STFP_SEL_TOKEN);
assign turn_take = tx_take_in & (tx_sel_out == `STFP_SEL_TOKEN_TURN);
// the item leaving on this edge must not be chosen again from its stale pending bit
assign pass_token_go = pend_pass_q & ~pass_take & (pass_gap_q >= `STFP_MIN_GAP);
assign turn_token_go = pend_turn_q & ~turn_take
    & (~pend_turn_kind_q | (turn_gap_q >= `STFP_MIN_GAP));

// ****************************************
// token loss timer and spacing counters
// ****************************************
always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        token_loss_timer_q <= 32'h0;
        pass_gap_q <= 7'h64;
        turn_gap_q <= 7'h64;
    end else begin
        if ((tx_take_in && (tx_sel_out == `STFP_SEL_TOKEN))
                || (tx_take_in && (tx_sel_out == `STFP_SEL_TOKEN_TURN) && pend_turn_kind_q)
                || loss_hit) begin
            token_loss_timer_q <= 32'h0;
        end else begin
            token_loss_timer_q <= token_loss_timer_q + 32'h1;
        end
        if (tx_take_in && (tx_sel_out == `STFP_SEL_TOKEN)) begin
            pass_gap_q <= 7'h0;
        end else if (pass_gap_q < `STFP_MIN_GAP) begin
            pass_gap_q <= pass_gap_q + 7'h1;
        end
        if (tx_take_in && (tx_sel_out == `STFP_SEL_TOKEN_TURN) && pend_turn_kind_q) begin
            turn_gap_q <= 7'h0;
        end else if (turn_gap_q < `STFP_MIN_GAP) begin
            turn_gap_q <= turn_gap_q + 7'h1;
        end
    end
end

// ****************************************
// token hold, release and quotas
// ****************************************
always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        token_held_out <= 1'b0;
        pend_pass_q <= 1'b0;
        pend_turn_q <= 1'b0;
        pend_turn_kind_q <= 1'b0;
        frame_count_out <= {QW{1'b0}};
        hold_quota_out <= {QW{1'b0}};
        idle_quota_out <= {QW{1'b0}};
        token_regen_out <= 1'b0;
    end else begin
        token_regen_out <= loss_hit;
        if (cfg_valid_in) begin
            hold_quota_out <= cfg_hold_quota_in;
            idle_quota_out <= cfg_idle_quota_in;
        end
        // token arriving while one is held merges into it
        if (tok_in && !token_held_out && !pend_pass_q && !pend_turn_q) begin
            token_held_out <= 1'b1;
        end else if (release_tok) begin
            token_held_out <= 1'b0;
            if (reflect_flag_in) begin
                pend_turn_q <= 1'b1;
                pend_turn_kind_q <= 1'b1;
            end else begin
                pend_pass_q <= 1'b1;
            end
        end
        // turn marker received: turned back as plain token or passed on at once
        if (rx_token_turn_in && char_sync_in && !pend_turn_q && !pend_pass_q
                && !token_held_out) begin
            if (reflect_flag_in) begin
                pend_turn_q <= 1'b1;
                pend_turn_kind_q <= 1'b0;
            end else begin
                pend_pass_q <= 1'b1;
            end
        end
        if (tx_take_in && (tx_sel_out == `STFP_SEL_TOKEN)) begin
            pend_pass_q <= 1'b0;
        end
        if (tx_take_in && (tx_sel_out == `STFP_SEL_TOKEN_TURN)) begin
            pend_turn_q <= 1'b0;
        end
        if (release_tok) begin
            frame_count_out <= {QW{1'b0}};
        end else if (own_frame_sent_in && (frame_count_out != {QW{1'b1}})) begin
            frame_count_out <= frame_count_out + {{(QW-1){1'b0}}, 1'b1};
        end
    end
end

// ****************************************
// ready flag run and status
// ****************************************
always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        flag_cnt_q <= 4'h0;
        ready_d1_q <= 1'b0;
        satisfied_out <= 1'b0;
        app_allowed_out <= 1'b0;
        rr_turn_q <= 1'b0;
    end else begin
        ready_d1_q <= ready_state_in;
        if (ready_state_in && !ready_d1_q) begin
            flag_cnt_q <= 4'h0;
        end else if (tx_take_in && (tx_sel_out == `STFP_SEL_FLAG)
                && (flag_cnt_q < `STFP_READY_FLAGS)) begin
            flag_cnt_q <= flag_cnt_q + 4'h1;
        end
        satisfied_out <= sat_now;
        app_allowed_out <= (token_held_out & ~sat_now)
            | (~cut_frame_pending_in & (idle_quota_out > frame_count_out));
        if (tx_take_in && ((tx_sel_out == `STFP_SEL_CUT)
                || (tx_sel_out == `STFP_SEL_OWN_APP))) begin
            rr_turn_q <= ~rr_turn_q;
        end
    end
end

// ****************************************
// transmit priority selector
// ****************************************
always @* begin
    sel_d = `STFP_SEL_IDLE_FLAG;
    if (disabled_state_in) begin
        sel_d = `STFP_SEL_DIS;
    end else if (ready_state_in && (!ready_d1_q
            || (flag_cnt_q + {3'h0, flag_take}) < `STFP_READY_FLAGS)) begin
        sel_d = `STFP_SEL_FLAG;
    end else if (pair_second_pending_in) begin
        sel_d = `STFP_SEL_PAIR2;
    end else if (ready_state_in && pass_token_go) begin
        sel_d = `STFP_SEL_TOKEN;
    end else if (ready_state_in && turn_token_go) begin
        sel_d = `STFP_SEL_TOKEN_TURN;
    end else if (user_char_pending_in) begin
        sel_d = `STFP_SEL_USER;
    end else if (ack_pair_pending_in) begin
        sel_d = `STFP_SEL_ACK;
    end else if (rr_pair_pending_in) begin
        sel_d = `STFP_SEL_RR;
    end else if (frame_in_progress_in) begin
        sel_d = `STFP_SEL_FRAME;
    end else if (fwd_ctrl_pending_in) begin
        sel_d = `STFP_SEL_FWD_CTRL;
    end else if (own_ctrl_pending_in) begin
        sel_d = `STFP_SEL_OWN_CTRL;
    end else if (ready_state_in && !awaiting_receiver_ready_flag_in) begin
        if (cut_frame_pending_in && own_app_pending_in && app_allowed_out) begin
            if (switch_node_in) begin
                sel_d = rr_turn_q ? `STFP_SEL_OWN_APP : `STFP_SEL_CUT;
            end else if (token_held_out) begin
                sel_d = `STFP_SEL_OWN_APP;
            end else begin
                sel_d = `STFP_SEL_CUT;
            end
        end else if (cut_frame_pending_in) begin
            sel_d = `STFP_SEL_CUT;
        end else if (own_app_pending_in && app_allowed_out) begin
            sel_d = `STFP_SEL_OWN_APP;
        end
    end
end

// registered so the selection holds until the transmitter takes it
always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        tx_sel_out <= `STFP_SEL_NONE;
    end else if (tx_take_in || (tx_sel_out == `STFP_SEL_NONE)) begin
        tx_sel_out <= sel_d;
    end
end

endmodule // stfp_port
`default_nettype wire

// ==== stfp_port_asserts.sv ====
// assertions on the port's transmit selection and token timing
// assumes binding onto stfp_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module stfp_port_asserts #(
    parameter LOSS_CYCLES = 1000000,
    parameter QW = 8
) (
    // clock, reset and inputs
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ready_state_in,
    input wire logic tx_take_in,
    input wire logic awaiting_receiver_ready_flag_in,
    input wire logic cfg_valid_in,
    input wire logic [QW-1:0] cfg_hold_quota_in,
    // outputs
    input wire logic [3:0] tx_sel_out,
    input wire logic token_held_out,
    input wire logic [QW-1:0] frame_count_out,
    input wire logic [QW-1:0] hold_quota_out,
    input wire logic token_regen_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // cycles since last pass (unbounded and capped at 100), ready flags taken
    int loss_q, pass_q, flag_q;
    wire pass_take = tx_take_in && tx_sel_out == 4'h2;
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            loss_q <= 0;
            pass_q <= 100;
            flag_q <= 0;
        end else begin
            // sent turn markers also restart the loss timer, but only passes count here, so loss_q can run past the port's timer
            loss_q <= pass_take ? 0 : loss_q + 1;
            pass_q <= pass_take ? 0 : (pass_q < 100 ? pass_q + 1 : 100);
            flag_q <= ready_state_in ? flag_q + int'(tx_take_in && tx_sel_out == 4'h0) : 0;
        end
    end
    property p_regen_pulse; token_regen_out |=> !token_regen_out; endproperty
    a_regen_pulse: assert property (p_regen_pulse) else $error("regen too long");
    property p_regen_gap; token_regen_out |-> loss_q >= LOSS_CYCLES - 2; endproperty
    a_regen_gap: assert property (p_regen_gap) else $error("regen too early");
    property p_pass_gap; pass_take |-> pass_q >= 99; endproperty
    a_pass_gap: assert property (p_pass_gap) else $error("passes too close");
    property p_flags; tx_take_in && tx_sel_out == 4'h0 && ready_state_in && flag_q < 9
        |=> !ready_state_in || tx_sel_out == 4'h0; endproperty
    a_flags: assert property (p_flags) else $error("ready flags cut short");
    property p_tok_ready; $past(tx_take_in, 2) && !$past(tx_take_in)
        && !$past(ready_state_in, 2) && !$past(ready_state_in, 3)
        |-> tx_sel_out != 4'h2 && tx_sel_out != 4'h3; endproperty
    a_tok_ready: assert property (p_tok_ready) else $error("token sent unready");
    property p_app_wait; $past(tx_take_in, 2) && !$past(tx_take_in)
        && $past(awaiting_receiver_ready_flag_in, 2) && $past(awaiting_receiver_ready_flag_in, 3)
        |-> tx_sel_out != 4'ha && tx_sel_out != 4'hb; endproperty
    a_app_wait: assert property (p_app_wait) else $error("frame while waiting");
    property p_frame_clr; $fell(token_held_out) |-> ##[0:1] frame_count_out == 0; endproperty
    a_frame_clr: assert property (p_frame_clr) else $error("count not cleared");
    property p_cfg; cfg_valid_in |=> hold_quota_out == $past(cfg_hold_quota_in); endproperty
    a_cfg: assert property (p_cfg) else $error("quota not loaded");
endmodule // stfp_port_asserts
bind stfp_port stfp_port_asserts #(.LOSS_CYCLES(LOSS_CYCLES), .QW(QW)) u_stfp_port_asserts (.*);
`default_nettype wire

// ==== stfp_remote_node.sv ====
// neighbouring port: sends token characters, counts those it receives
// assumes a take pulse marks each character leaving the local port
`timescale 1ns/1ps
`default_nettype none
module stfp_remote_node (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // link side
    input wire logic [3:0] sel_in,
    input wire logic take_in,
    output var logic rx_token_out,
    output var logic [7:0] seen_out,
    output var logic [3:0] last_out
);
    initial rx_token_out = 1'b0;
    task automatic send_token;
        @(negedge mclk_in) rx_token_out = 1'b1;
        @(negedge mclk_in) rx_token_out = 1'b0;
    endtask
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_out <= 8'h00;
            last_out <= 4'h0;
        end else if (take_in && (sel_in == 4'h2 || sel_in == 4'h3)) begin
            seen_out <= seen_out + 8'h01;
            last_out <= sel_in;
        end
    end
endmodule // stfp_remote_node
`default_nettype wire

// ==== stfp_port_bench.sv ====
// self-checking bench for the token timing and transmit priority port
// assumes the remote node model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "stfp_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module stfp_port_bench;
    reg mclk_in = 0, rst_n_in = 0, ready_state_in = 0, disabled_state_in = 1, char_sync_in = 1;
    reg reflect_flag_in = 0, switch_node_in = 0, cfg_valid_in = 0, rx_token_turn_in = 0;
    reg [7:0] cfg_hold_quota_in = 8'h00, cfg_idle_quota_in = 8'h00;
    reg own_frame_sent_in = 0, own_frame_pending_in = 0, tx_take_in = 0;
    reg pair_second_pending_in = 0, user_char_pending_in = 0, ack_pair_pending_in = 0;
    reg rr_pair_pending_in = 0, frame_in_progress_in = 0, fwd_ctrl_pending_in = 0;
    reg own_ctrl_pending_in = 0, cut_frame_pending_in = 0, own_app_pending_in = 0;
    reg awaiting_receiver_ready_flag_in = 0;
    reg [8:0] v;
    wire rx_token_in, token_held_out, satisfied_out, app_allowed_out, token_regen_out;
    wire [3:0] tx_sel_out, last_tok;
    wire [7:0] frame_count_out, hold_quota_out, idle_quota_out, seen_tok;
    integer num_errors = 0, tests_run = 0, seed = 32'hf0e8, i;
    always #50 mclk_in = ~mclk_in;
    stfp_port #(.LOSS_CYCLES(2000)) u_stfp_port (.*);
    stfp_remote_node u_stfp_remote_node (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .sel_in(tx_sel_out), .take_in(tx_take_in), .rx_token_out(rx_token_in),
        .seen_out(seen_tok), .last_out(last_tok));
    // highest pending item wins; waiting for receiver ready blocks cut-through and own application frames
    function [3:0] pick(input [8:0] p, input w);
        reg [35:0] codes;
        codes = 36'hba9876541;
        pick = `STFP_SEL_IDLE_FLAG;
        for (int k = 8; k >= 0; k--)
            if (p[k] && !(k > 6 && w)) pick = codes[k*4 +: 4];
    endfunction
    task setp(input [8:0] p);
        {own_app_pending_in, cut_frame_pending_in, own_ctrl_pending_in, fwd_ctrl_pending_in,
            frame_in_progress_in, rr_pair_pending_in, ack_pair_pending_in,
            user_char_pending_in, pair_second_pending_in} = p;
    endtask
    task tk;
        @(negedge mclk_in) tx_take_in = 1;
        @(negedge mclk_in) tx_take_in = 0;
        @(negedge mclk_in);
    endtask
    task run(input integer n);
        repeat (n) @(negedge mclk_in) tx_take_in = 1;
        @(negedge mclk_in) tx_take_in = 0;
    endtask
    task complete_run;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        num_errors++;
        complete_run;
    end
    initial begin
        cfg_hold_quota_in = 8'h01 + {6'h00, 2'($random(seed))};
        cfg_idle_quota_in = cfg_hold_quota_in << 2;
        repeat (8) @(negedge mclk_in);
        rst_n_in = 1;
        @(negedge mclk_in) cfg_valid_in = 1;
        @(negedge mclk_in) cfg_valid_in = 0;
        `CHK(hold_quota_out, cfg_hold_quota_in)
        `CHK(idle_quota_out, cfg_idle_quota_in)
        tk;
        `CHK(tx_sel_out, `STFP_SEL_DIS)
        ready_state_in = 1;
        disabled_state_in = 0;
        for (i = 0; i < 10; i++) begin
            tk;
            `CHK(tx_sel_out, `STFP_SEL_FLAG)
        end
        for (i = 0; i < 40; i++) begin
            v = (i == 0) ? 9'h000 : (i == 1) ? 9'h180 : 9'($random(seed));
            awaiting_receiver_ready_flag_in = (i == 1) ? 1'b1 : 1'($random(seed));
            setp(v);
            tk;
            `CHK(tx_sel_out, pick(v, awaiting_receiver_ready_flag_in))
            `CHK(tx_sel_out, pick(v, awaiting_receiver_ready_flag_in))
        end
        setp(9'h180);
        awaiting_receiver_ready_flag_in = 0;
        own_frame_pending_in = 1;
        u_stfp_remote_node.send_token;
        repeat (3) @(negedge mclk_in);
        `CHK(token_held_out, 1'b1)
        tk;
        `CHK(tx_sel_out, `STFP_SEL_OWN_APP)
        u_stfp_remote_node.send_token;
        setp(9'h002);
        repeat (cfg_hold_quota_in) begin
            @(negedge mclk_in) own_frame_sent_in = 1;
            @(negedge mclk_in) own_frame_sent_in = 0;
        end
        own_frame_pending_in = 0;
        run(10);
        `CHK(seen_tok, 8'h01)
        `CHK(frame_count_out, 8'h00)
        run(150);
        `CHK(seen_tok, 8'h01)
        setp(9'h000);
        reflect_flag_in = 1;
        u_stfp_remote_node.send_token;
        run(12);
        `CHK(last_tok, `STFP_SEL_TOKEN_TURN)
        u_stfp_remote_node.send_token;
        run(12);
        `CHK(seen_tok, 8'h02)
        run(100);
        `CHK(seen_tok, 8'h03)
        reflect_flag_in = 0;
        run(2050);
        `CHK(seen_tok, 8'h04)
        complete_run;
    end
endmodule // stfp_port_bench
`default_nettype wire
